// >>> fpd_pkg.sv
// Shared types and constants for the float processor datapath sequencer
package fpd_pkg;
  localparam int DW     = 28;  // Working register width
  localparam int WW     = 12;  // Host memory word width
  localparam int AW     = 15;  // Host address width
  localparam int SCW    = 6;   // Shift counter width
  localparam int FLDW   = 3;   // Field bit width
  localparam int NREQ   = 4;   // Request paths per address register
  localparam int NSYNC  = 4;   // Host pins passed through the synchroniser
  // Synchroniser bit positions
  localparam int SY_NOBRK = 0;
  localparam int SY_BRKON = 1;
  localparam int SY_ACCPT = 2;
  localparam int SY_MRDN  = 3;
  // Values after reset
  localparam logic [3:0]      RST_MAJOR = 4'h0;
  localparam logic [DW-1:0]   RST_WORD  = 28'h0000000;
  localparam logic [WW-1:0]   RST_DATA  = 12'h000;
  localparam logic [AW-1:0]   RST_ADDR  = 15'h0000;
  localparam logic [NSYNC-1:0] RST_SYNC = 4'h9;  // Idle host pin levels
  // Mini states per major state
  localparam logic [2:0] MINI_COUNT = 3'h4;
  // Function selects (S3..S0)
  localparam logic [3:0] ALU_SUB  = 4'h6;
  localparam logic [3:0] ALU_ADD  = 4'h9;
  localparam logic [3:0] ALU_DBL  = 4'hC;
  localparam logic [3:0] ALU_PASS = 4'hF;
  localparam logic [3:0] ALU_ONES = 4'h3;
  localparam logic [3:0] ALU_B    = 4'hA;

  typedef enum logic [1:0] {BRK_OUT, BRK_IN, BRK_INC} fpd_kind_e;
  typedef enum logic [1:0] {ADR_OPND, ADR_FPC, ADR_APT} fpd_adr_e;
  typedef enum logic [1:0] {
    DSRC_FIELD, DSRC_OPND, DSRC_BLOW, DSRC_AHIGH
  } fpd_dsrc_e;
  typedef enum logic [2:0] {
    MX_FAC, MX_XBASE, MX_BASE, MX_OREG, MX_MQ, MX_SHCNT, MX_MB, MX_ZERO
  } fpd_mux_e;

  // Per mini state enables, sampled at the edge that opens the mini state
  typedef struct packed {
    logic [3:0] alu_s;
    logic       inh_carry;
    logic       carry_in;
    fpd_mux_e   amux;
    fpd_mux_e   bmux;
    logic       a_load;
    logic       a_comp;
    logic       a_clr;
    logic       b_load;
    logic       b_shift;
    logic       b_clr;
    logic       b_ser;
    logic       o_load;
    logic       o_shift;
    logic       o_clr;
    logic       o_ser;
    logic       mb_to_a;
    logic       mb_hi;
  } fpd_ctl_s;

  // Registers outside the core that feed its multiplexers
  typedef struct packed {
    logic [DW-1:0]   fac;
    logic [DW-1:0]   xbase;
    logic [DW-1:0]   base;
    logic [DW-1:0]   mq;
    logic [SCW-1:0]  shcnt;
    logic [AW-1:0]   opnd;
    logic [AW-1:0]   float_program_counter;
    logic [AW-1:0]   active_parameter_table;
    logic [FLDW-1:0] apt_field;
  } fpd_src_s;

  // Break request paths from the state enables
  typedef struct packed {
    logic [NREQ-1:0] req_opnd;
    logic [NREQ-1:0] req_fpc;
    logic [NREQ-1:0] req_apt;
    fpd_kind_e       kind;
    fpd_dsrc_e       dsrc;
  } fpd_brk_s;
endpackage

// >>> fpd_core.sv
// Datapath, timing generator and data break control of the float core
// Functional notes
// - A storage register, B shifts toward LSB
// - O register loads, shifts toward MSB
// - ALU fed by A,B; drives O
// - Break address from one of three registers
// - A/B multiplexer from six register sources
// - Register action needs enable plus clock pulse
// - Selects held a mini state; clock late
// - Request while latched and idle; drop on break
// - Drive bus on own break or maintenance
// - Input break gates data onto bus
// - Address-accept trailing edge restarts timing
// - ORed paths set latch, choose address
// - Output, input and increment break kinds
// - Four input break data sources
// - Multiplexer resolves eight sub-sources
// - Sixteen major states, jump anywhere
// - Wait for advance, then four mini pulses
// - Next major state one clock after fourth
// - Output break mini 1 captures memory word
// - A loads true or complemented input
// - ALU select codes per function table
// - A minus B via complement plus carry
`timescale 1ns/1ps
`default_nettype none
module fpd_core
  import fpd_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  input  wire fpd_ctl_s        ctl_i,
  input  wire fpd_src_s        src_i,
  input  wire fpd_brk_s        brk_i,
  input  wire logic            advance_i,
  input  wire logic            jump_i,
  input  wire logic [3:0]      jump_state_i,
  input  wire logic            no_break_i,
  input  wire logic            break_active_i,
  input  wire logic            addr_accept_i,
  input  wire logic            maintenance_read_n_i,
  input  wire logic [WW-1:0]   memory_buffer_word_i,
  output logic                 break_request_out_n_o,
  output fpd_kind_e            break_kind_o,
  output logic [AW-1:0]        external_addr_lines_o,
  output logic [WW-1:0]        external_data_lines_o,
  output logic                 bus_data_drive_enable_o,
  output logic                 data_oe_n_o,
  output logic [3:0]           major_state_o,
  output logic [3:0]           mini_pulse_o,
  output logic [DW-1:0]        a_reg_o,
  output logic [DW-1:0]        b_reg_o,
  output logic [DW-1:0]        o_reg_o
);
  typedef enum logic [2:0] {TG_WAIT, TG_M1, TG_M2, TG_M3, TG_M4, TG_GAP}
    fpd_tg_e;

  // Function table; unused codes give zero
  function automatic logic [DW-1:0] alu_f(input logic [3:0] s,
      input logic ic, input logic ci, input logic [DW-1:0] a,
      input logic [DW-1:0] b);
    logic [DW-1:0] c;
    c = (!ic && ci) ? 28'h0000001 : 28'h0000000;
    alu_f = 28'h0000000;
    if (!ic) begin
      unique case (s)
        ALU_SUB:  alu_f = a + ~b + c;  // Carry in completes two's complement
        ALU_ADD:  alu_f = a + b + c;
        ALU_DBL:  alu_f = a + a + c;
        ALU_PASS: alu_f = a + c;
        default:  alu_f = 28'h0000000;
      endcase
    end else begin
      unique case (s)
        ALU_ONES: alu_f = 28'hFFFFFFF;
        ALU_B:    alu_f = b;
        default:  alu_f = 28'h0000000;
      endcase
    end
  endfunction

  // Eight-way source multiplexer shared by A and B
  function automatic logic [DW-1:0] mux_f(input fpd_mux_e sel,
      input fpd_src_s s, input logic [DW-1:0] o, input logic [WW-1:0] mb);
    unique case (sel)
      MX_FAC:   mux_f = s.fac;
      MX_XBASE: mux_f = s.xbase;
      MX_BASE:  mux_f = s.base;
      MX_OREG:  mux_f = o;
      MX_MQ:    mux_f = s.mq;
      MX_SHCNT: mux_f = {22'h000000, s.shcnt};
      MX_MB:    mux_f = {16'h0000, mb};
      MX_ZERO:  mux_f = 28'h0000000;
    endcase
  endfunction

  // Host pins: three stages, value accepted when stages two and three agree
  logic [NSYNC-1:0] sy1_ff, sy2_ff, sy3_ff, pin_ff;
  logic [NSYNC-1:0] nxt_pin;
  always_comb begin
    for (int i = 0; i < NSYNC; i++) begin
      nxt_pin[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] : pin_ff[i];
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sy1_ff <= RST_SYNC;
      sy2_ff <= RST_SYNC;
      sy3_ff <= RST_SYNC;
      pin_ff <= RST_SYNC;
    end else begin
      sy1_ff <= {maintenance_read_n_i, addr_accept_i, break_active_i,
                 no_break_i};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      pin_ff <= nxt_pin;
    end
  end

  logic accept_fall, maint_rd;
  assign accept_fall = pin_ff[SY_ACCPT] && !nxt_pin[SY_ACCPT];
  assign maint_rd    = !pin_ff[SY_MRDN];

  // Break control state
  logic            req_ff, nxt_req, done_ff, nxt_done;
  fpd_adr_e        adr_ff, nxt_adr;
  fpd_kind_e       kind_ff, nxt_kind;
  logic [AW-1:0]   addr_ff, nxt_addr;
  logic [WW-1:0]   data_ff, nxt_data;
  logic [DW-1:0]   amux, bmux;
  fpd_ctl_s        ctl_ff;
  fpd_tg_e         tg_ff, nxt_tg;
  logic [3:0]      maj_ff, nxt_maj;
  logic            any_opnd, any_fpc, any_apt;

  assign any_opnd = |brk_i.req_opnd;
  assign any_fpc  = |brk_i.req_fpc;
  assign any_apt  = |brk_i.req_apt;
  assign amux = mux_f(ctl_ff.amux, src_i, o_reg_o, memory_buffer_word_i);
  assign bmux = mux_f(ctl_ff.bmux, src_i, o_reg_o, memory_buffer_word_i);

  // Latch a request while waiting; address register is fixed with it
  always_comb begin
    nxt_req  = req_ff;
    nxt_adr  = adr_ff;
    nxt_kind = kind_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_done = accept_fall && req_ff;
    if (req_ff && accept_fall) begin
      nxt_req = 1'b0;
    end else if (!req_ff && tg_ff == TG_WAIT
                 && (any_opnd || any_fpc || any_apt)) begin
      nxt_req  = 1'b1;
      nxt_kind = brk_i.kind;
      nxt_adr  = any_opnd ? ADR_OPND : (any_fpc ? ADR_FPC : ADR_APT);
      unique case (nxt_adr)
        ADR_OPND: nxt_addr = src_i.opnd;
        ADR_FPC:  nxt_addr = src_i.float_program_counter;
        default:  nxt_addr = src_i.active_parameter_table;
      endcase
      unique case (brk_i.dsrc)
        DSRC_FIELD: nxt_data = {9'h000, src_i.apt_field};
        DSRC_OPND:  nxt_data = src_i.opnd[WW-1:0];
        DSRC_BLOW:  nxt_data = bmux[WW-1:0];
        DSRC_AHIGH: nxt_data = amux[2*WW-1:WW];
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_ff  <= 1'b0;
      done_ff <= 1'b0;
      adr_ff  <= ADR_OPND;
      kind_ff <= BRK_OUT;
      addr_ff <= RST_ADDR;
      data_ff <= RST_DATA;
    end else begin
      req_ff  <= nxt_req;
      done_ff <= nxt_done;
      adr_ff  <= nxt_adr;
      kind_ff <= nxt_kind;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
    end
  end

  // Request is dropped as soon as the host shows the break has begun
  assign break_request_out_n_o = !(req_ff && pin_ff[SY_NOBRK]);
  assign bus_data_drive_enable_o = (pin_ff[SY_BRKON] && req_ff)
                                   || maint_rd;
  // Only input breaks put data on the lines, except maintenance reads
  assign data_oe_n_o = !(bus_data_drive_enable_o
                         && (kind_ff == BRK_IN || maint_rd));
  assign external_data_lines_o = data_ff;
  assign external_addr_lines_o = addr_ff;
  assign break_kind_o          = kind_ff;

  // Timing generator: wait, four mini pulses, one idle clock, next state
  always_comb begin
    nxt_tg  = tg_ff;
    nxt_maj = maj_ff;
    unique case (tg_ff)
      TG_WAIT: if (advance_i || done_ff) nxt_tg = TG_M1;
      TG_M1:   nxt_tg = TG_M2;
      TG_M2:   nxt_tg = TG_M3;
      TG_M3:   nxt_tg = TG_M4;
      TG_M4:   nxt_tg = TG_GAP;
      TG_GAP: begin
        nxt_tg  = TG_WAIT;
        nxt_maj = maj_ff + 4'h1;
      end
      default: nxt_tg = TG_WAIT;
    endcase
    if (jump_i) begin
      nxt_tg  = TG_WAIT;
      nxt_maj = jump_state_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tg_ff  <= TG_WAIT;
      maj_ff <= RST_MAJOR;
      ctl_ff <= '0;
    end else begin
      tg_ff  <= nxt_tg;
      maj_ff <= nxt_maj;
      ctl_ff <= ctl_i;  // Selects stay still for the whole mini state
    end
  end

  assign major_state_o = maj_ff;
  assign mini_pulse_o  = {tg_ff == TG_M4, tg_ff == TG_M3,
                          tg_ff == TG_M2, tg_ff == TG_M1};

  // Register gating: the action lands on the edge that closes the pulse,
  // a full period after the selects changed, so data has settled
  logic            clk_pulse;
  logic [DW-1:0]   a_ff, b_ff, o_ff, nxt_a, nxt_b, nxt_o, alu_y;
  assign clk_pulse = |mini_pulse_o;
  assign alu_y = alu_f(ctl_ff.alu_s, ctl_ff.inh_carry, ctl_ff.carry_in,
                       a_ff, b_ff);
  always_comb begin
    nxt_a = a_ff;
    nxt_b = b_ff;
    nxt_o = o_ff;
    if (clk_pulse) begin
      if (ctl_ff.a_clr) nxt_a = RST_WORD;
      else if (ctl_ff.a_load)
        nxt_a = ctl_ff.a_comp ? ~amux : amux;
      if (ctl_ff.mb_to_a && kind_ff == BRK_OUT && tg_ff == TG_M1) begin
        if (ctl_ff.mb_hi) nxt_a[2*WW-1:WW] = memory_buffer_word_i;
        else nxt_a[WW-1:0] = memory_buffer_word_i;
      end
      if (ctl_ff.b_clr) nxt_b = RST_WORD;
      else if (ctl_ff.b_load) nxt_b = bmux;
      else if (ctl_ff.b_shift) nxt_b = {ctl_ff.b_ser, b_ff[DW-1:1]};
      if (ctl_ff.o_clr) nxt_o = RST_WORD;
      else if (ctl_ff.o_load) nxt_o = alu_y;
      else if (ctl_ff.o_shift) nxt_o = {o_ff[DW-2:0], ctl_ff.o_ser};
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      a_ff <= RST_WORD;
      b_ff <= RST_WORD;
      o_ff <= RST_WORD;
    end else begin
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      o_ff <= nxt_o;
    end
  end
  assign a_reg_o = a_ff;
  assign b_reg_o = b_ff;
  assign o_reg_o = o_ff;

  property p_req_drop;
    @(posedge clk_i) disable iff (sys_rst_i)
      !pin_ff[SY_NOBRK] |-> break_request_out_n_o;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("break request held during break");
  property p_drive;
    @(posedge clk_i) disable iff (sys_rst_i)
      bus_data_drive_enable_o |-> (req_ff && pin_ff[SY_BRKON]) || maint_rd;
  endproperty
  a_drive: assert property (p_drive)
    else $error("bus driven without own break");
  property p_minis;
    @(posedge clk_i) disable iff (sys_rst_i || jump_i)
      $rose(mini_pulse_o[0]) |=> mini_pulse_o[1] ##1 mini_pulse_o[2]
        ##1 mini_pulse_o[3];
  endproperty
  a_minis: assert property (p_minis)
    else $error("mini pulses out of order");
  property p_next_major;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mini_pulse_o[3] && !jump_i) ##1 !jump_i
        |=> major_state_o == $past(major_state_o, 2) + 4'h1;
  endproperty
  a_next_major: assert property (p_next_major)
    else $error("major state did not step");
  property p_jump;
    @(posedge clk_i) disable iff (sys_rst_i)
      jump_i |=> major_state_o == $past(jump_state_i) && !clk_pulse;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not taken");
  property p_restart;
    @(posedge clk_i) disable iff (sys_rst_i)
      (accept_fall && req_ff && tg_ff == TG_WAIT && !jump_i)
        |=> ##1 mini_pulse_o[0];
  endproperty
  a_restart: assert property (p_restart)
    else $error("accept edge did not restart timing");
  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !clk_pulse |=> a_reg_o == $past(a_reg_o) && o_reg_o == $past(o_reg_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed outside clock pulse");
  property p_oload;
    @(posedge clk_i) disable iff (sys_rst_i)
      clk_pulse && ctl_ff.o_load && !ctl_ff.o_clr |=> o_reg_o == $past(alu_y);
  endproperty
  a_oload: assert property (p_oload)
    else $error("O did not take the ALU output");
  property p_bshift;
    @(posedge clk_i) disable iff (sys_rst_i)
      clk_pulse && ctl_ff.b_shift && !ctl_ff.b_load && !ctl_ff.b_clr
        |=> b_reg_o[DW-2:0] == $past(b_reg_o[DW-1:1]);
  endproperty
  a_bshift: assert property (p_bshift)
    else $error("B shift wrong direction");
endmodule
`default_nettype wire

// >>> fpd_host_model.sv
// Host memory port model that grants single-cycle data breaks
`timescale 1ns/1ps
`default_nettype none
module fpd_host_model
  import fpd_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic [3:0]    delay_i,
  input  wire logic          req_n_i,
  input  wire fpd_kind_e     kind_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [WW-1:0] data_i,
  input  wire logic          drive_i,
  output logic               no_break_o,
  output logic               active_o,
  output logic               accept_o,
  output logic [WW-1:0]      mb_o
);
  logic [WW-1:0] mem [16];
  int            cnt;

  // Position dependent pattern so each address reads back distinctly
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 12'hA50 ^ WW'(i);
    end
  end

  // Grant after delay_i cycles; accept is held long enough for the
  // device's pin synchroniser to see break active before data is taken
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      no_break_o <= 1'b1;
      active_o <= 1'b0;
      accept_o <= 1'b0;
      mb_o <= 12'h5A5;
    end else begin
      // Word held while the break lasts, scrambled once released
      mb_o <= (cnt > delay_i) ? mem[addr_i[3:0]] : ~mb_o;
      if (cnt == 0) begin
        cnt <= req_n_i ? 0 : 1;
      end else begin
        cnt <= (cnt == delay_i + 16) ? 0 : cnt + 1;
      end
      if (cnt != 0 && cnt == delay_i + 1) begin
        no_break_o <= 1'b0;
        active_o <= 1'b1;
        accept_o <= 1'b1;
      end
      if (cnt != 0 && cnt == delay_i + 6) begin
        accept_o <= 1'b0;  // Trailing edge restarts the device
        if (drive_i && kind_i == BRK_IN) begin
          mem[addr_i[3:0]] <= data_i;
        end
        if (kind_i == BRK_INC) begin
          mem[addr_i[3:0]] <= mem[addr_i[3:0]] + 12'h001;
        end
      end
      if (cnt == delay_i + 7) begin
        active_o <= 1'b0;
      end
      if (cnt == delay_i + 16) begin
        no_break_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> fpd_core_bench.sv
// Self-checking bench for the float datapath sequencer core
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module float_proc_datapath_sequencer_bench
  import fpd_pkg::*;
;
  typedef struct packed {
    logic [3:0]    s;
    logic          inh;
    logic          ci;
    logic          cmp;
    logic [DW-1:0] res;
  } fpd_row_s;
  localparam logic [DW-1:0] A_VAL = 28'h1234567;
  localparam logic [DW-1:0] B_VAL = 28'h0ABCDEF;
  // Function rows: select, inhibit, carry, complement A, result in O
  fpd_row_s alu_tab [9] = '{
    '{ALU_SUB, 1'b0, 1'b1, 1'b0, 28'h0777778},
    '{ALU_ADD, 1'b0, 1'b0, 1'b0, 28'h1CF1356},
    '{ALU_DBL, 1'b0, 1'b0, 1'b0, 28'h2468ACE},
    '{ALU_PASS, 1'b0, 1'b0, 1'b0, 28'h1234567},
    '{ALU_PASS, 1'b0, 1'b1, 1'b0, 28'h1234568},
    '{ALU_ONES, 1'b1, 1'b0, 1'b0, 28'hFFFFFFF},
    '{ALU_B, 1'b1, 1'b0, 1'b0, 28'h0ABCDEF},
    '{ALU_DBL, 1'b1, 1'b0, 1'b0, 28'h0000000},
    '{ALU_ADD, 1'b0, 1'b1, 1'b1, 28'hF888888}
  };
  // Break rows: path (3 = all), kind, data source, expectations
  int            bsel [5] = '{0, 1, 2, 1, 3};
  fpd_kind_e     bkind [5] = '{BRK_OUT, BRK_IN, BRK_INC, BRK_OUT, BRK_OUT};
  fpd_dsrc_e     bdsrc [5] = '{DSRC_FIELD, DSRC_OPND, DSRC_BLOW,
                               DSRC_AHIGH, DSRC_BLOW};
  logic [AW-1:0] baddr [5] = '{15'h4A63, 15'h2005, 15'h3007, 15'h2005,
                               15'h4A63};
  logic [WW-1:0] bdata [5] = '{12'h005, 12'hA63, 12'hDEF, 12'h234, 12'hDEF};
  logic [WW-1:0] bmb [5] = '{12'hA53, 12'h000, 12'h000, 12'hA63, 12'hA53};
  // Expected A and B per multiplexer code, O holding the shifted result
  logic [DW-1:0] mx_exp [6] = '{A_VAL, 28'h0369CF1, B_VAL, 28'hF111110,
                                28'h5A5A5A5, 28'h000002B};
  logic          clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  fpd_ctl_s      ctl_i = '0;
  fpd_src_s      src_i = '0;
  fpd_brk_s      brk_i = '0;
  logic          advance_i = 1'b0;
  logic          jump_i = 1'b0;
  logic [3:0]    jump_state_i = 4'h0;
  logic          maintenance_read_n_i = 1'b1;
  logic [3:0]    delay = 4'h0;
  logic          no_break_i, break_active_i, addr_accept_i;
  logic [WW-1:0] memory_buffer_word_i, external_data_lines_o;
  logic          break_request_out_n_o, bus_data_drive_enable_o, data_oe_n_o;
  fpd_kind_e     break_kind_o;
  logic [AW-1:0] external_addr_lines_o;
  logic [3:0]    major_state_o, mini_pulse_o;
  logic [DW-1:0] a_reg_o, b_reg_o, o_reg_o;
  int            error_cnt = 0;
  int            check_count = 0;
  int            cycles = 0;
  fpd_ctl_s      c1, c2;

  fpd_core dut_u (
    .clk_i, .sys_rst_i, .ctl_i, .src_i, .brk_i, .advance_i, .jump_i,
    .jump_state_i, .no_break_i, .break_active_i, .addr_accept_i,
    .maintenance_read_n_i, .memory_buffer_word_i, .break_request_out_n_o,
    .break_kind_o, .external_addr_lines_o, .external_data_lines_o,
    .bus_data_drive_enable_o, .data_oe_n_o, .major_state_o, .mini_pulse_o,
    .a_reg_o, .b_reg_o, .o_reg_o
  );
  fpd_host_model host_u (
    .clk_i, .sys_rst_i, .delay_i(delay), .req_n_i(break_request_out_n_o),
    .kind_i(break_kind_o), .addr_i(external_addr_lines_o),
    .data_i(external_data_lines_o), .drive_i(bus_data_drive_enable_o),
    .no_break_o(no_break_i), .active_o(break_active_i),
    .accept_o(addr_accept_i), .mb_o(memory_buffer_word_i)
  );

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Ceiling far above the roughly 400 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Counts: errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One advanced major state; f1 acts in mini 1, f2 in mini 2
  task automatic run_state(input fpd_ctl_s f1, input fpd_ctl_s f2);
    logic [3:0] m;
    m = major_state_o;
    ctl_i = f1;
    advance_i = 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      #1;
      advance_i = 1'b0;
      ctl_i = (k == 0) ? f2 : '0;
      `CHK(mini_pulse_o, 4'h1 << k)
    end
    @(posedge clk_i);
    #1;
    `CHK(major_state_o, m + 4'h1)
  endtask

  // One break from table row i; the host delay grows with the row
  task automatic do_break(input int i);
    logic dseen;
    logic oseen;
    dseen = 1'b0;
    oseen = 1'b0;
    ctl_i.mb_hi = (i == 3);  // Row 3 fills the high word of A
    delay = 4'(i * 3);
    brk_i.kind = bkind[i];
    brk_i.dsrc = bdsrc[i];
    brk_i.req_opnd[i % 4] = (bsel[i] == 0 || bsel[i] == 3);
    brk_i.req_fpc[i % 4] = (bsel[i] == 1 || bsel[i] == 3);
    brk_i.req_apt[i % 4] = (bsel[i] >= 2);
    @(posedge clk_i);
    #1;
    brk_i = '0;
    `CHK(external_addr_lines_o, baddr[i])
    `CHK(external_data_lines_o, bdata[i])
    `CHK(break_kind_o, bkind[i])
    `CHK(break_request_out_n_o, 1'b0)
    for (int k = 0; k < 80 && mini_pulse_o !== 4'h1; k++) begin
      @(posedge clk_i);
      #1;
      dseen |= bus_data_drive_enable_o;
      oseen |= !data_oe_n_o;
    end
    `CHK(mini_pulse_o, 4'h1)
    `CHK(break_request_out_n_o, 1'b1)
    `CHK(dseen, 1'b1)
    `CHK(oseen, bkind[i] == BRK_IN)
    @(posedge clk_i);
    #1;
    if (bkind[i] == BRK_OUT && i == 3) begin
      `CHK(a_reg_o[2*WW-1:WW], bmb[i])
    end else if (bkind[i] == BRK_OUT) begin
      `CHK(a_reg_o[WW-1:0], bmb[i])
    end
    repeat (30) @(posedge clk_i);
    #1;
  endtask

  // Main sequence: function table rows first, then the hand-written cases around the break rows
  initial begin
    src_i.fac = A_VAL;
    src_i.base = B_VAL;
    src_i.opnd = 15'h4A63;
    src_i.float_program_counter = 15'h2005;
    src_i.active_parameter_table = 15'h3007;
    src_i.apt_field = 3'h5;
    src_i.xbase = 28'h0369CF1;
    src_i.mq = 28'h5A5A5A5;
    src_i.shcnt = 6'h2B;
    repeat (12) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    `CHK({a_reg_o, b_reg_o, o_reg_o}, {3{RST_WORD}})
    `CHK({major_state_o, mini_pulse_o, break_request_out_n_o}, 9'h001)
    for (int r = 0; r < 9; r++) begin
      c1 = '0;
      c1.amux = MX_FAC;
      c1.bmux = MX_BASE;
      c1.a_load = 1'b1;
      c1.b_load = 1'b1;
      c1.a_comp = alu_tab[r].cmp;
      c2 = '0;
      c2.o_load = 1'b1;
      c2.alu_s = alu_tab[r].s;
      c2.inh_carry = alu_tab[r].inh;
      c2.carry_in = alu_tab[r].ci;
      run_state(c1, c2);
      `CHK(a_reg_o, alu_tab[r].cmp ? ~A_VAL : A_VAL)
      `CHK(b_reg_o, B_VAL)
      `CHK(o_reg_o, alu_tab[r].res)
    end
    // Shifts with zero serial input, then clears beating a load
    c1 = '0;
    c1.b_shift = 1'b1;
    c1.o_shift = 1'b1;
    c2 = '0;
    run_state(c1, c2);
    `CHK(b_reg_o, B_VAL >> 1)
    `CHK(o_reg_o, 28'hF111110)
    // Every register source of the A and B multiplexers in turn
    for (int m = 0; m < 6; m++) begin
      c1 = '0;
      c1.amux = fpd_mux_e'(m);
      c1.bmux = fpd_mux_e'(m);
      c1.a_load = 1'b1;
      c1.b_load = 1'b1;
      run_state(c1, c2);
      `CHK(a_reg_o, mx_exp[m])
      `CHK(b_reg_o, mx_exp[m])
    end
    c1 = '0;
    c1.a_load = 1'b1;
    c1.a_clr = 1'b1;
    c1.b_clr = 1'b1;
    c1.o_clr = 1'b1;
    run_state(c1, c2);
    `CHK({a_reg_o, b_reg_o, o_reg_o}, {3{RST_WORD}})
    // A load enable held in the wait state must do nothing
    c2.amux = MX_FAC;
    c2.a_load = 1'b1;
    ctl_i = c2;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(a_reg_o, RST_WORD)
    ctl_i = '0;
    ctl_i.mb_to_a = 1'b1;
    ctl_i.amux = MX_FAC;
    ctl_i.bmux = MX_BASE;
    for (int i = 0; i < 5; i++) begin
      do_break(i);
    end
    ctl_i = '0;
    maintenance_read_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK({bus_data_drive_enable_o, data_oe_n_o}, 2'b10)
    maintenance_read_n_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK({bus_data_drive_enable_o, data_oe_n_o}, 2'b01)
    // Reset in mid-run clears the datapath and the timing generator
    sys_rst_i = 1'b1;
    @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    `CHK({a_reg_o, b_reg_o, o_reg_o}, {3{RST_WORD}})
    `CHK({major_state_o, mini_pulse_o, break_request_out_n_o}, 9'h001)
    for (int s = 15; s >= 0; s--) begin
      jump_i = 1'b1;
      jump_state_i = 4'(s);
      @(posedge clk_i);
      #1;
      jump_i = 1'b0;
      `CHK(major_state_o, 4'(s))
    end
    run_state(ctl_i, ctl_i);
    complete_run();
  end
endmodule
`default_nettype wire
